//--- core/svd_ctrl.sv
// Supply voltage detector control: registers, modes, masking, events
//
// Functional notes
// - Control register byte wide, resets to zero
// - Detector reset keeps control; others clear enable; code keeps enable over a detector reset in interrupt-reset mode only
// - Mask and flag bits are read only
// - Flag one only while supply below threshold
// - Rewrite enable writable in interrupt-reset mode only
// - Mask forced during enable and settle waits
// - Level register byte wide, kept on detector reset except level select in interrupt-reset mode
// - Level reset value 00, 81 or 01
// - Level select zero high, one low threshold
// - Level select writable in interrupt-reset mode only
// - Hardware updates level select on detector events; code does so in interrupt-reset mode only
// - Option byte fields decoded as laid out
// - Interrupt-reset mode low code and high choice
// - Mode bits: 10 both, 11 reset, 01 interrupt
// - Supply flag sits at control bit zero
// - Detector reset sets reset cause flag
`timescale 1ns/1ps
module svd_ctrl
  import svd_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_por_rst_b,
  input wire logic [7:0] i_opt_byte,
  input wire logic i_rst_by_detector,
  input wire logic i_supply_below,
  input wire svd_bus_req_t i_bus,
  output logic [7:0] o_rd_data,
  output logic o_det_reset_req,
  output logic o_det_irq,
  output logic o_level_low,
  output logic [2:0] o_low_code,
  output logic [1:0] o_high_sel,
  output logic o_det_enable,
  output logic o_reset_cause_set
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_BOOT, ST_LOAD, ST_RUN} svd_state_t;

  svd_state_t state; // Start-up sequencer
  logic [1:0] boot_cnt; // Cycles spent syncing straps
  logic [7:0] opt_s1; // Option byte sync, first stage
  logic [7:0] opt_s2; // Option byte sync, second stage
  logic cause_s1; // Reset cause sync stages
  logic cause_s2;
  logic below_s1; // Comparator sync stages
  logic below_s2;
  logic below_d; // Previous comparator level
  svd_opt_t opt; // Decoded option byte
  logic rewrite_en; // Level rewrite enable, survives detector reset in interrupt-reset mode
  logic lvl_sel; // Threshold level select, survives detector reset outside interrupt-reset mode
  logic lvl_top; // Upper level register bit
  logic settle_start; // Kick the stabilisation wait
  logic settle_busy; // Stabilisation wait running
  logic mask_status; // Detector output masked
  logic supply_flag; // Supply below current threshold
  logic run; // Normal operation
  logic is_irq_rst; // Interrupt and reset mode
  logic hi_irq_evt; // High threshold crossed downward
  logic lo_rst_evt; // Low threshold crossed, reset needed
  logic wr_ctrl; // Control register write
  logic wr_lvl; // Level register write
  logic lvl_wr_ok; // Level write accepted
  logic next_lvl_sel;

  // Register byte decode, shared by reads and writes
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  // Strap, cause and comparator come from outside this clock
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      opt_s1 <= 8'h00;
      opt_s2 <= 8'h00;
      cause_s1 <= 1'b0;
      cause_s2 <= 1'b0;
      below_s1 <= 1'b0;
      below_s2 <= 1'b0;
      below_d <= 1'b0;
    end else begin
      opt_s1 <= i_opt_byte;
      opt_s2 <= opt_s1;
      cause_s1 <= i_rst_by_detector;
      cause_s2 <= cause_s1;
      below_s1 <= i_supply_below;
      below_s2 <= below_s1;
      below_d <= below_s2;
    end
  end

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  svd_opt_decode u_decode (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_opt(opt_s2),
    .o_opt(opt)
  );

  svd_settle_timer #(
    .CYCLES(SETTLE)
  ) u_settle (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_start(settle_start),
    .o_busy(settle_busy)
  );

  // ----------------------------------------------------------------
  // Start-up sequencer
  // ----------------------------------------------------------------
  // Reset values depend on the strap, so they load only once it settled
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= ST_BOOT;
      boot_cnt <= 2'h0;
    end else begin
      case (state)
        ST_BOOT: begin
          boot_cnt <= boot_cnt + 2'h1;
          if (boot_cnt == BOOT_CYCLES) begin
            state <= ST_LOAD;
          end
        end
        ST_LOAD: state <= ST_RUN;
        ST_RUN: state <= ST_RUN;
        default: state <= ST_BOOT;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Combinational decode
  // ----------------------------------------------------------------
  always_comb begin
    run = (state == ST_RUN);
    is_irq_rst = (opt.mode == SVD_MODE_IRQ_RST);
    // Mask only exists in interrupt and reset mode
    mask_status = is_irq_rst && (rewrite_en || settle_busy);
    supply_flag = below_s2 && !opt.det_off && (opt.mode != SVD_MODE_OFF);
    hi_irq_evt = run && is_irq_rst && !mask_status && !lvl_sel && below_s2;
    lo_rst_evt = run && is_irq_rst && !mask_status && lvl_sel && below_s2;
    wr_ctrl = run && i_bus.wr && hit(i_bus.addr, CTRL_OFS);
    wr_lvl = run && i_bus.wr && hit(i_bus.addr, LVL_OFS);
    lvl_wr_ok = wr_lvl && rewrite_en && is_irq_rst;
    // Hardware event wins over a software write in the same cycle
    if (hi_irq_evt) begin
      next_lvl_sel = 1'b1;
    end else if (lvl_wr_ok) begin
      next_lvl_sel = i_bus.wdata[LVL_SEL_BIT];
    end else begin
      next_lvl_sel = lvl_sel;
    end
    settle_start = (state == ST_LOAD && is_irq_rst && cause_s2)
                   || (run && (next_lvl_sel != lvl_sel));
  end

  // ----------------------------------------------------------------
  // Level rewrite enable
  // ----------------------------------------------------------------
  // Power-on clears it; a system reset is handled at load time
  always_ff @(posedge i_clk or negedge i_por_rst_b) begin
    if (!i_por_rst_b) begin
      rewrite_en <= CTRL_RST[CTRL_REWRITE_BIT];
    end else if (state == ST_LOAD) begin
      if (!cause_s2 || !is_irq_rst) begin
        rewrite_en <= 1'b0;
      end
    end else if (wr_ctrl && is_irq_rst) begin
      rewrite_en <= i_bus.wdata[CTRL_REWRITE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Level select register
  // ----------------------------------------------------------------
  // Kept across a detector reset, except that interrupt-reset mode clears the level select
  always_ff @(posedge i_clk or negedge i_por_rst_b) begin
    if (!i_por_rst_b) begin
      lvl_sel <= LVL_RST_IRQ_RST[LVL_SEL_BIT];
      lvl_top <= LVL_RST_IRQ_RST[LVL_TOP_BIT];
    end else if (state == ST_LOAD) begin
      if (!cause_s2) begin
        case (opt.mode)
          SVD_MODE_RST: begin
            lvl_sel <= LVL_RST_RST[LVL_SEL_BIT];
            lvl_top <= LVL_RST_RST[LVL_TOP_BIT];
          end
          SVD_MODE_IRQ: begin
            lvl_sel <= LVL_RST_IRQ[LVL_SEL_BIT];
            lvl_top <= LVL_RST_IRQ[LVL_TOP_BIT];
          end
          default: begin
            lvl_sel <= LVL_RST_IRQ_RST[LVL_SEL_BIT];
            lvl_top <= LVL_RST_IRQ_RST[LVL_TOP_BIT];
          end
        endcase
      end else if (is_irq_rst) begin
        lvl_sel <= 1'b0;
      end
    end else begin
      lvl_sel <= next_lvl_sel;
    end
  end

  // ----------------------------------------------------------------
  // Detector outputs to reset and interrupt logic
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_det_reset_req <= 1'b0;
      o_det_irq <= 1'b0;
    end else begin
      case (opt.mode)
        SVD_MODE_IRQ_RST: begin
          o_det_reset_req <= lo_rst_evt;
          o_det_irq <= hi_irq_evt;
        end
        SVD_MODE_RST: begin
          o_det_reset_req <= run && below_s2;
          o_det_irq <= 1'b0;
        end
        SVD_MODE_IRQ: begin
          // Pulse on each crossing in either direction
          o_det_reset_req <= 1'b0;
          o_det_irq <= run && (below_s2 != below_d);
        end
        default: begin
          o_det_reset_req <= 1'b0;
          o_det_irq <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Comparator setup and reset cause
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_level_low <= 1'b0;
      o_low_code <= 3'h0;
      o_high_sel <= 2'h0;
      o_det_enable <= 1'b0;
      o_reset_cause_set <= 1'b0;
    end else begin
      o_level_low <= lvl_sel;
      o_low_code <= opt.low_code;
      o_high_sel <= opt.sub_sel;
      o_det_enable <= run && (opt.mode != SVD_MODE_OFF);
      // One pulse toward the reset cause register
      o_reset_cause_set <= (state == ST_LOAD) && cause_s2;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  // Data stands the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd_data <= 8'h00;
    end else if (i_bus.rd) begin
      if (hit(i_bus.addr, CTRL_OFS)) begin
        o_rd_data <= {rewrite_en, 5'h00, mask_status, supply_flag};
      end else if (hit(i_bus.addr, LVL_OFS)) begin
        o_rd_data <= {lvl_top, 6'h00, lvl_sel};
      end else if (hit(i_bus.addr, OPT_OFS)) begin
        o_rd_data <= opt_s2;
      end else begin
        o_rd_data <= 8'h00;
      end
    end else begin
      o_rd_data <= 8'h00;
    end
  end

endmodule // svd_ctrl

//--- core/svd_opt_decode.sv
// Decoder of the option byte into mode and threshold selections
`timescale 1ns/1ps
module svd_opt_decode
  import svd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_opt,
  output svd_opt_t o_opt
);

  // ----------------------------------------------------------------
  // Registered decode
  // ----------------------------------------------------------------
  // Unlisted encodings fall back to detector off
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_opt <= '0;
    end else begin
      case (i_opt[OPT_MODE_HI:OPT_MODE_LO])
        MODE_CODE_IRQ_RST: o_opt.mode <= SVD_MODE_IRQ_RST;
        MODE_CODE_RST: o_opt.mode <= i_opt[OPT_LOW_HI] ? SVD_MODE_OFF : SVD_MODE_RST;
        MODE_CODE_IRQ: o_opt.mode <= i_opt[OPT_LOW_HI] ? SVD_MODE_OFF : SVD_MODE_IRQ;
        default: o_opt.mode <= SVD_MODE_OFF;
      endcase
      o_opt.det_off <= (i_opt[OPT_MODE_HI:OPT_MODE_LO] == 2'h0)
                       || (i_opt[OPT_LOW_HI] && i_opt[OPT_MODE_LO]);
      // Interrupt and reset mode only uses the lower two code bits
      if (i_opt[OPT_MODE_HI:OPT_MODE_LO] == MODE_CODE_IRQ_RST) begin
        o_opt.low_code <= {1'b0, i_opt[OPT_LOW_HI-1:OPT_LOW_LO]};
      end else begin
        o_opt.low_code <= i_opt[OPT_LOW_HI:OPT_LOW_LO];
      end
      o_opt.sub_sel <= i_opt[OPT_SUB_HI:OPT_SUB_LO];
    end
  end

endmodule // svd_opt_decode

//--- core/svd_pkg.sv
// Package: constants and types of the supply voltage detector control block
package svd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8; // Register address width
  localparam logic [7:0] CTRL_OFS = 8'h00; // Detector control flags
  localparam logic [7:0] LVL_OFS = 8'h01; // Detector level select
  localparam logic [7:0] OPT_OFS = 8'hc1; // Option byte, read only

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_REWRITE_BIT = 7; // Level rewrite enable
  localparam int CTRL_MASK_BIT = 1; // Output mask status
  localparam int CTRL_FLAG_BIT = 0; // Supply below flag
  localparam int LVL_SEL_BIT = 0; // Threshold level select
  localparam int LVL_TOP_BIT = 7; // Mode-dependent upper bit
  localparam int OPT_LOW_HI = 7; // Low threshold code field
  localparam int OPT_LOW_LO = 5;
  localparam int OPT_FIXED_BIT = 4; // Always one
  localparam int OPT_SUB_HI = 3; // Threshold sub-select field
  localparam int OPT_SUB_LO = 2;
  localparam int OPT_MODE_HI = 1; // Mode select field
  localparam int OPT_MODE_LO = 0;

  // ----------------------------------------------------------------
  // Values after reset and option byte mode codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] LVL_RST_IRQ_RST = 8'h00;
  localparam logic [7:0] LVL_RST_RST = 8'h81;
  localparam logic [7:0] LVL_RST_IRQ = 8'h01;
  localparam logic [1:0] MODE_CODE_IRQ_RST = 2'h2;
  localparam logic [1:0] MODE_CODE_RST = 2'h3;
  localparam logic [1:0] MODE_CODE_IRQ = 2'h1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000; // 125 MHz
  localparam int SETTLE_TIME_NS = 1000; // Sense level stabilisation wait
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [1:0] BOOT_CYCLES = 2'h3; // Strap sync plus decode

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SVD_MODE_OFF,
    SVD_MODE_IRQ_RST,
    SVD_MODE_RST,
    SVD_MODE_IRQ
  } svd_mode_t;

  typedef struct packed {
    svd_mode_t mode; // Operating mode
    logic det_off; // Detector switched off
    logic [2:0] low_code; // Low threshold code
    logic [1:0] sub_sel; // Threshold sub-select
  } svd_opt_t;

  typedef struct packed {
    logic wr; // Write strobe
    logic rd; // Read strobe
    logic [ADDR_W-1:0] addr; // Register address
    logic [7:0] wdata; // Write data
  } svd_bus_req_t;

endpackage

//--- core/svd_settle_timer.sv
// Stabilisation wait timer for the sense level
`timescale 1ns/1ps
module svd_settle_timer
  import svd_pkg::*;
#(
  parameter int CYCLES = SETTLE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_start,
  output logic o_busy
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);

  logic [CW-1:0] count; // Cycles left in the wait

  // ----------------------------------------------------------------
  // Down counter, restart extends the wait
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count <= '0;
      o_busy <= 1'b0;
    end else if (i_start) begin
      count <= LOAD;
      o_busy <= 1'b1;
    end else if (count > CW'(1)) begin
      count <= count - CW'(1);
    end else begin
      count <= '0;
      o_busy <= 1'b0;
    end
  end

endmodule // svd_settle_timer

//--- tb/svd_ctrl_props.sv
// Port checker for the detector control block, bound to svd_ctrl
`timescale 1ns/1ps
module svd_ctrl_props
  import svd_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_opt_byte,
  input wire logic i_rst_by_detector,
  input wire svd_bus_req_t i_bus,
  input wire logic [7:0] o_rd_data,
  input wire logic o_det_reset_req,
  input wire logic o_det_irq,
  input wire logic o_level_low,
  input wire logic [2:0] o_low_code,
  input wire logic [1:0] o_high_sel,
  input wire logic o_det_enable,
  input wire logic o_reset_cause_set
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic [3:0] run_cnt; // Edges since release, saturates well past boot
  wire logic mode_ir = i_opt_byte[1:0] == MODE_CODE_IRQ_RST;
  wire logic mode_off = (i_opt_byte[1:0] == 2'h0) || (i_opt_byte[7] && i_opt_byte[0]);

  // Strap sync and boot end by edge six; level and option reads sampled before edge nine are skipped
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      run_cnt <= 4'h0;
    end else if (run_cnt != 4'hf) begin
      run_cnt <= run_cnt + 4'h1;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_rd_ctrl;
    i_bus.rd && i_bus.addr == CTRL_OFS;
  endsequence
  sequence s_rd_lvl;
    run_cnt > 4'h7 && i_bus.rd && i_bus.addr == LVL_OFS;
  endsequence
  property p_rd_idle;
    !i_bus.rd |=> o_rd_data == 8'h00;
  endproperty
  property p_ctrl_bits;
    s_rd_ctrl |=> o_rd_data[6:2] == 5'h00;
  endproperty
  property p_flag_off;
    s_rd_ctrl and mode_off |=> !o_rd_data[CTRL_FLAG_BIT];
  endproperty
  property p_lvl_top;
    s_rd_lvl |=> o_rd_data[LVL_TOP_BIT] == (i_opt_byte[1:0] == MODE_CODE_RST);
  endproperty
  property p_opt_read;
    run_cnt > 4'h7 && i_bus.rd && i_bus.addr == OPT_OFS |=> o_rd_data == i_opt_byte;
  endproperty
  property p_codes;
    o_det_enable |-> o_low_code == i_opt_byte[7:5] && o_high_sel == i_opt_byte[3:2];
  endproperty
  property p_irq_level;
    // Level output is a registered copy, so it follows the pulse by one edge
    o_det_irq && mode_ir |=> o_level_low;
  endproperty
  property p_irq_masked;
    o_det_irq && mode_ir |=> !o_det_irq [*3];
  endproperty
  property p_rst_no_irq;
    i_opt_byte[1:0] == MODE_CODE_RST |-> !o_det_irq;
  endproperty
  property p_irq_no_req;
    i_opt_byte[1:0] == MODE_CODE_IRQ && !i_opt_byte[7] |-> !o_det_reset_req;
  endproperty
  property p_cause;
    o_reset_cause_set |-> i_rst_by_detector ##1 !o_reset_cause_set;
  endproperty

  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
  a_ctrl_bits: assert property (p_ctrl_bits) else $error("control spare bits set");
  a_flag_off: assert property (p_flag_off) else $error("flag set with detector off");
  a_lvl_top: assert property (p_lvl_top) else $error("level upper bit wrong");
  a_opt_read: assert property (p_opt_read) else $error("option byte read wrong");
  a_codes: assert property (p_codes) else $error("threshold codes wrong");
  a_irq_level: assert property (p_irq_level) else $error("level not low after event");
  a_irq_masked: assert property (p_irq_masked) else $error("event during settle");
  a_rst_no_irq: assert property (p_rst_no_irq) else $error("event in reset mode");
  a_irq_no_req: assert property (p_irq_no_req) else $error("reset in event mode");
  a_cause: assert property (p_cause) else $error("cause pulse wrong");
endmodule // svd_ctrl_props

bind svd_ctrl svd_ctrl_props #(.SETTLE(SETTLE)) u_svd_ctrl_props (
  .i_clk(i_clk),
  .i_rst_b(i_rst_b),
  .i_opt_byte(i_opt_byte),
  .i_rst_by_detector(i_rst_by_detector),
  .i_bus(i_bus),
  .o_rd_data(o_rd_data),
  .o_det_reset_req(o_det_reset_req),
  .o_det_irq(o_det_irq),
  .o_level_low(o_level_low),
  .o_low_code(o_low_code),
  .o_high_sel(o_high_sel),
  .o_det_enable(o_det_enable),
  .o_reset_cause_set(o_reset_cause_set)
);

//--- tb/svd_supply_model.sv
// Model of the analogue comparator and the system reset logic
`timescale 1ns/1ps
module svd_supply_model #(
  parameter int HIGH_MV = 2900, // Upper threshold, plain value
  parameter int LOW_MV = 1700 // Lower or single threshold, plain value
) (
  input wire logic i_clk,
  input wire logic i_ext_rst_b,
  input wire logic i_ext_by_det,
  input wire logic [15:0] i_vdd_mv,
  input wire logic i_det_enable,
  input wire logic i_level_low,
  input wire logic i_reset_req,
  output logic o_supply_below,
  output logic o_rst_b,
  output logic o_by_det
);
  // ----------------------------------------------------------------
  // Comparator and reset hold
  // ----------------------------------------------------------------
  logic [1:0] hold; // Reset pulse length left
  logic det_seen; // Last reset came from the detector

  // Compare against the selected level; off means never below
  assign o_supply_below = i_det_enable
                          && (i_vdd_mv < (i_level_low ? LOW_MV : HIGH_MV));

  // A reset request pulls system reset for three edges and marks the cause
  always_ff @(posedge i_clk or negedge i_ext_rst_b) begin
    if (!i_ext_rst_b) begin
      hold <= 2'h0;
      det_seen <= 1'b0;
    end else if (i_reset_req && hold == 2'h0) begin
      hold <= 2'h3;
      det_seen <= 1'b1;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end
  end

  assign o_rst_b = i_ext_rst_b && hold == 2'h0;
  assign o_by_det = i_ext_by_det || det_seen;
endmodule // svd_supply_model

//--- tb/test_supply_voltage_detect_ctrl.sv
// Self-checking testbench of the detector control block
`timescale 1ns/1ps
module test_supply_voltage_detect_ctrl;
  import svd_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic i_clk = 1'b0;
  logic ext_rst_b = 1'b0; // Bench reset
  logic por_b = 1'b0; // Power-on reset
  logic ext_by_det = 1'b0; // Bench-forced detector cause
  logic [7:0] opt = 8'h3a;
  logic [15:0] vdd = 16'd3300; // Supply in millivolts
  svd_bus_req_t bus = '0;
  logic rst_b, by_det, below, req, irq, lvl_low, det_en, cause;
  logic [7:0] o_rd_data;
  logic [2:0] o_low_code;
  logic [1:0] o_high_sel;
  int num_errors = 0;
  int n_tests = 0;
  logic [7:0] opts [3] = '{8'h3a, 8'h57, 8'h79};
  logic [7:0] lvl_rst [3] = '{LVL_RST_IRQ_RST, LVL_RST_RST, LVL_RST_IRQ};
  wire logic [2:0] evt = {cause, req, irq};

  always #4 i_clk = ~i_clk; // 125 MHz

  svd_ctrl #(.SETTLE(4)) u_svd_ctrl (
    .i_clk(i_clk), .i_rst_b(rst_b), .i_por_rst_b(por_b), .i_opt_byte(opt),
    .i_rst_by_detector(by_det), .i_supply_below(below), .i_bus(bus),
    .o_rd_data(o_rd_data), .o_det_reset_req(req), .o_det_irq(irq),
    .o_level_low(lvl_low), .o_low_code(o_low_code), .o_high_sel(o_high_sel),
    .o_det_enable(det_en), .o_reset_cause_set(cause));

  svd_supply_model u_svd_supply_model (
    .i_clk(i_clk), .i_ext_rst_b(ext_rst_b), .i_ext_by_det(ext_by_det),
    .i_vdd_mv(vdd), .i_det_enable(det_en), .i_level_low(lvl_low),
    .i_reset_req(req), .o_supply_below(below), .o_rst_b(rst_b), .o_by_det(by_det));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Gap cycle after each strobe keeps one assignment per time step
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk) bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk) bus <= '0;
  endtask

  // Data stand only in the cycle after the strobe, sampled mid-cycle
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk) bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk) bus <= '0;
    @(negedge i_clk);
    check(n, o_rd_data, e);
  endtask

  // Bounded wait for a one-cycle or level event
  task automatic wait_evt(input int b, input string n);
    for (int k = 0; k < 60 && evt[b] !== 1'b1; k++) @(negedge i_clk);
    check(n, {7'h00, evt[b]}, 8'h01);
  endtask

  // Strap moves only under reset; writes are refused until RUN, so wait past boot
  task automatic do_reset(input logic por, input logic det, input logic [7:0] o);
    @(posedge i_clk);
    ext_rst_b <= 1'b0;
    por_b <= ~por;
    ext_by_det <= det;
    opt <= o;
    repeat (2) @(posedge i_clk);
    ext_rst_b <= 1'b1;
    por_b <= 1'b1;
    repeat (9) @(posedge i_clk);
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    for (int m = 0; m < 3; m++) begin
      vdd <= 16'd3300;
      do_reset(1'b1, 1'b0, opts[m]);
      rd_chk("ctrl_rst", CTRL_OFS, CTRL_RST);
      rd_chk("lvl_rst", LVL_OFS, lvl_rst[m]);
      rd_chk("opt", OPT_OFS, opts[m]);
      check("low_code", {5'h00, o_low_code}, {5'h00, opts[m][7:5]});
      check("high_sel", {6'h00, o_high_sel}, {6'h00, opts[m][3:2]});
      check("det_en", {7'h00, det_en}, 8'h01);
      bus_wr(LVL_OFS, (m == 0) ? 8'h01 : 8'h00);
      rd_chk("lvl_locked", LVL_OFS, lvl_rst[m]);
      bus_wr(CTRL_OFS, 8'h83);
      rd_chk("ctrl_en", CTRL_OFS, (m == 0) ? 8'h82 : 8'h00);
      if (m == 0) begin
        bus_wr(LVL_OFS, 8'h01);
        rd_chk("lvl_sw1", LVL_OFS, 8'h01);
        check("level_low", {7'h00, lvl_low}, 8'h01);
        bus_wr(LVL_OFS, 8'h00);
        rd_chk("lvl_sw0", LVL_OFS, 8'h00);
        bus_wr(CTRL_OFS, 8'h00);
        bus_wr(LVL_OFS, 8'h01);
        rd_chk("lvl_dis", LVL_OFS, 8'h00);
        repeat (10) @(posedge i_clk);
        rd_chk("ctrl_dis", CTRL_OFS, 8'h00);
        vdd <= 16'd2500;
        wait_evt(0, "irq");
        // Level output is registered, one edge behind the event
        @(negedge i_clk);
        check("lvl_hw", {7'h00, lvl_low}, 8'h01);
        vdd <= 16'd1500;
        wait_evt(1, "rst_req");
        vdd <= 16'd3300;
        wait_evt(2, "cause");
        repeat (10) @(posedge i_clk);
        rd_chk("lvl_back", LVL_OFS, 8'h00);
        bus_wr(CTRL_OFS, 8'h80);
        do_reset(1'b0, 1'b1, opt);
        rd_chk("ctrl_keep", CTRL_OFS, 8'h82);
        do_reset(1'b0, 1'b0, opt);
        rd_chk("ctrl_clr", CTRL_OFS, 8'h00);
      end else begin
        vdd <= 16'd1500;
        wait_evt((m == 1) ? 1 : 0, "mode_evt");
        if (m == 2) rd_chk("flag", CTRL_OFS, 8'h01);
        vdd <= 16'd3300;
      end
    end
    do_reset(1'b1, 1'b0, 8'h91);
    vdd <= 16'd1500;
    repeat (6) @(posedge i_clk);
    rd_chk("flag_off", CTRL_OFS, 8'h00);
    check("det_off", {7'h00, det_en}, 8'h00);
    bus_wr(8'h40, 8'hff);
    rd_chk("unmapped", 8'h40, 8'h00);
    tally_and_finish();
  end

  // Whole run is a few hundred cycles; cut a hang well beyond that
  initial begin
    #160000;
    num_errors++;
    tally_and_finish();
  end
endmodule // test_supply_voltage_detect_ctrl
